/* File: hw/afe_cfg_pkg.sv */
// constants shared by the converter front-end configuration bank
package afe_cfg_pkg;
   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register indices on the plain register port
   localparam logic [3:0] REG_SUPPLY   = 4'h0;
   localparam logic [3:0] REG_GAIN     = 4'h1;
   localparam logic [3:0] REG_LINK     = 4'h2;
   localparam logic [3:0] REG_ENDS     = 4'h3;
   localparam logic [3:0] REG_RES_LO   = 4'h4;
   localparam logic [3:0] REG_RES_MID  = 4'h5;
   localparam logic [3:0] REG_RES_HI   = 4'h6;
   localparam logic [3:0] REG_CTRL_A   = 4'h7;
   localparam logic [3:0] REG_CTRL_B   = 4'h8;
   localparam logic [3:0] REG_CLKDIV   = 4'h9;
   localparam logic [3:0] REG_DAC_HI   = 4'ha;
   localparam logic [3:0] REG_DAC_LO   = 4'hb;
   localparam logic [3:0] REG_DAC_CTRL = 4'hc;

   // implemented-bit masks; all other bits read zero
   localparam logic [7:0] MSK_SUPPLY   = 8'h87;
   localparam logic [7:0] MSK_GAIN     = 8'h7f;
   localparam logic [7:0] MSK_LINK     = 8'h7e;
   localparam logic [7:0] MSK_ENDS     = 8'h3f;
   localparam logic [7:0] MSK_CTRL_A   = 8'hfd;
   localparam logic [7:0] MSK_CTRL_B   = 8'hfe;
   localparam logic [7:0] MSK_CLKDIV   = 8'h1f;
   localparam logic [7:0] MSK_DAC_HI   = 8'hff;
   localparam logic [7:0] MSK_DAC_LO   = 8'h0f;
   localparam logic [7:0] MSK_DAC_CTRL = 8'he0;
   localparam logic [7:0] MSK_RESULT   = 8'hff;

   // power-on values
   localparam logic [7:0] RST_ZERO   = 8'h00;
   localparam logic [7:0] RST_CTRL_A = 8'h20;

   // field positions
   localparam int SUP_ON_BIT   = 7;
   localparam int SUP_BPS_BIT  = 2;
   localparam int A_RST_BIT    = 7;
   localparam int A_SLP_BIT    = 6;
   localparam int A_OFF_BIT    = 5;
   localparam int A_OSR_LSB    = 2;
   localparam int A_VREF_BIT   = 0;
   localparam int B_FLM_LSB    = 5;
   localparam int B_BUFN_BIT   = 4;
   localparam int B_BUFP_BIT   = 3;
   localparam int B_LATCH_BIT  = 2;
   localparam int B_EOC_BIT    = 1;
   localparam int G_REF_LSB    = 5;
   localparam int G_IN_LSB     = 3;
   localparam int L_SHORT_BIT  = 6;
   localparam int L_XOVER_LSB  = 4;
   localparam int L_OFS_LSB    = 1;
   localparam int E_NEG_LSB    = 3;
   localparam int DC_EN_BIT    = 7;
   localparam int DC_REF_LSB   = 5;

   // rate arithmetic
   localparam int         DIV_N_SLOW    = 30;
   localparam int         DIV_N_FAST    = 12;
   localparam int         SAMPLE_DOUBLING_FACTOR_DOUBLE   = 2;
   localparam int         SAMPLE_DOUBLING_FACTOR_SINGLE   = 1;
   localparam int         OSR_MAX       = 16384;
   localparam logic [4:0] CLKDIV_DIRECT = 5'h1f;

   // routing source positions in a one-hot route vector
   localparam int SRC_AIN_A = 0;
   localparam int SRC_AIN_B = 1;
   localparam int SRC_DAC   = 2;
   localparam int SRC_GND   = 3;
   localparam int SRC_CM    = 4;
   localparam int SRC_TEMP  = 5;
endpackage : afe_cfg_pkg

/* File: hw/mod_clock_div.sv */
// modulator clock source divider, emits one tick per modulator clock
`timescale 1ns/1ns
module mod_clock_div
   import afe_cfg_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // divide select
   input  wire logic [4:0] div_sel,
   // modulator tick
   output logic            mclk_tick
);
   typedef struct packed {
      logic [5:0] cnt;   // core cycles in the current period
      logic       tick;  // registered tick
   } div_state_t;

   div_state_t s_r;
   div_state_t s_nxt;

   // all-ones runs straight on core clock, else 2*(div+1)
   always_comb begin
      s_nxt = s_r;
      if (ce) begin
         s_nxt.tick = 1'b0;
         if (div_sel == CLKDIV_DIRECT) begin
            s_nxt.tick = 1'b1;
            s_nxt.cnt  = 6'h00;
         end else if (s_r.cnt >= {div_sel, 1'b1}) begin
            s_nxt.tick = 1'b1;
            s_nxt.cnt  = 6'h00;
         end else begin
            s_nxt.cnt = s_r.cnt + 6'h01;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rstn) s_r <= '0;
      else       s_r <= s_nxt;
   end

   assign mclk_tick = s_r.tick;

   property p_direct;
      @(posedge core_clk) disable iff (!rstn)
      ce && div_sel == CLKDIV_DIRECT |=> mclk_tick;
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct source did not tick every cycle");
endmodule : mod_clock_div

/* File: hw/word_rate_div.sv */
// counts modulator ticks into output word slots
`timescale 1ns/1ns
module word_rate_div
   import afe_cfg_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // rate controls
   input  wire logic       run,
   input  wire logic       mclk_tick,
   input  wire logic [2:0] filter_mode,
   input  wire logic [2:0] osr_sel,
   // word slot pulse
   output logic            word_tick
);
   typedef struct packed {
      logic [19:0] cnt;   // modulator ticks in this word
      logic        tick;  // registered word pulse
   } rate_state_t;

   rate_state_t s_r;
   rate_state_t s_nxt;

   // modulator ticks per word: n * sample_doubling_factor * osr
   function automatic logic [19:0] word_len(input logic [2:0] fm,
                                            input logic [2:0] os);
      word_len = 20'((fm[1] ? DIV_N_FAST : DIV_N_SLOW)
                   * (fm[2] ? SAMPLE_DOUBLING_FACTOR_SINGLE : SAMPLE_DOUBLING_FACTOR_DOUBLE)
                   * (OSR_MAX >> os));
   endfunction : word_len

   // held cleared while the converter is stopped
   always_comb begin
      s_nxt = s_r;
      if (ce) begin
         s_nxt.tick = 1'b0;
         if (!run) begin
            s_nxt.cnt = 20'h00000;
         end else if (mclk_tick) begin
            // >= so a shorter setting ends the word at once
            if (s_r.cnt >= word_len(filter_mode, osr_sel) - 20'h1) begin
               s_nxt.tick = 1'b1;
               s_nxt.cnt  = 20'h00000;
            end else begin
               s_nxt.cnt = s_r.cnt + 20'h00001;
            end
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rstn) s_r <= '0;
      else       s_r <= s_nxt;
   end

   assign word_tick = s_r.tick;

   property p_idle;
      @(posedge core_clk) disable iff (!rstn)
      !run |=> !word_tick;
   endproperty
   a_idle: assert property (p_idle)
      else $error("word pulse while converter stopped");
endmodule : word_rate_div

/* File: hw/adc_frontend_config_regs.sv */
// configuration register bank for the converter front end
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - level code picks 2.4/2.6/2.9/3.3 volts
// - regulator off only when powered off, disabled
// - bypass bit enables bypass, resets to zero
// - word rate is source over n*sample_doubling_factor*osr
// - source is core clock or halved, divided
// - filter mode picks sample_doubling_factor of two or one
// - reference gain 1, 1/2, 1/4; 11 reserved
// - input gain codes give 1,2,4,8
// - amplifier gain is two to the code
// - short bit ties both input ends together
// - offset codes give signed quarter steps
// - negative end routing per code, two reserved
// - positive end routing per code, two reserved
// - dac code split high byte, low nibble
// - unimplemented bits ignore writes, read zero
// - low code shadowed until high is written
// - power-off bit overrides sleep and reset
module adc_frontend_config_regs
   import afe_cfg_pkg::*;
(
   // clock, reset, enable
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [DATA_W-1:0] rdata,
   // converter status from the filter datapath
   input  wire logic [23:0]       result_word,
   input  wire logic              eoc_set,
   // supply regulator
   output logic [1:0]             regulator_level_sel,
   output logic                   regulator_on,
   output logic                   regulator_bypass,
   output logic                   regulator_power,
   output logic                   regulated_output_en,
   output logic                   common_mode_en,
   // converter control
   output logic                   converter_power_off,
   output logic                   converter_sleep,
   output logic                   converter_soft_reset,
   output logic [2:0]             oversampling_sel,
   output logic                   ext_reference_sel,
   output logic [2:0]             filter_mode_sel,
   output logic                   sample_doubling_factor,
   output logic                   ref_buf_neg_en,
   output logic                   ref_buf_pos_en,
   output logic                   data_latch_en,
   output logic [4:0]             modulator_clock_div,
   // gains and input network
   output logic [1:0]             reference_gain_sel,
   output logic [3:0]             converter_input_gain,
   output logic [7:0]             amplifier_gain,
   output logic                   input_short,
   output logic [1:0]             input_crossover_sel,
   output logic signed [2:0]      diff_offset_quarters,
   output logic [5:0]             positive_route,
   output logic [5:0]             negative_route,
   // dac
   output logic [11:0]            dac_code,
   output logic                   dac_enable,
   output logic [1:0]             dac_ref_sel,
   // rate pulses
   output logic                   modulator_tick,
   output logic                   word_rate_tick
);
   // the whole bank; bytes hold only implemented bits
   typedef struct packed {
      logic [7:0]        supply;    // regulator control
      logic [7:0]        gain;      // gain selects
      logic [7:0]        link;      // short, crossover, offset
      logic [7:0]        ends;      // input end selects
      logic [7:0]        ctrl_a;    // power, osr, reference
      logic [7:0]        ctrl_b;    // filter mode, buffers, eoc
      logic [7:0]        clkdiv;    // modulator clock divide
      logic [7:0]        dac_hi;    // dac code 11..4
      logic [7:0]        dac_lo;    // active dac code 3..0
      logic [7:0]        dac_shd;   // shadow of the low code
      logic [7:0]        dac_ctrl;  // dac enable, reference
      logic [7:0]        rdata;     // read answer
      logic              reg_pwr;   // regulator powered
      logic [7:0]        amp_gain;  // decoded amplifier gain
      logic [3:0]        in_gain;   // decoded input gain
      logic signed [2:0] offset;    // quarter steps
      logic [5:0]        pos_rt;    // one-hot positive route
      logic [5:0]        neg_rt;    // one-hot negative route
   } bank_t;

   // power-on image, decoded fields agree with the power-on codes
   localparam bank_t BANK_RST = '{
      supply:   RST_ZERO,
      gain:     RST_ZERO,
      link:     RST_ZERO,
      ends:     RST_ZERO,
      ctrl_a:   RST_CTRL_A,
      ctrl_b:   RST_ZERO,
      clkdiv:   RST_ZERO,
      dac_hi:   RST_ZERO,
      dac_lo:   RST_ZERO,
      dac_shd:  RST_ZERO,
      dac_ctrl: RST_ZERO,
      rdata:    RST_ZERO,
      reg_pwr:  1'b0,
      amp_gain: 8'h01,
      in_gain:  4'h1,
      offset:   3'sh0,
      pos_rt:   6'h01,
      neg_rt:   6'h01
   };

   bank_t s_r;    // registered bank
   bank_t s_nxt;  // next bank
   logic [7:0] rd_val;  // read mux result
   logic       conv_run; // converter allowed to produce words

   // implemented-bit mask per index; unmapped gives zero
   function automatic logic [7:0] reg_mask(input logic [3:0] a);
      case (a)
         REG_SUPPLY:   reg_mask = MSK_SUPPLY;
         REG_GAIN:     reg_mask = MSK_GAIN;
         REG_LINK:     reg_mask = MSK_LINK;
         REG_ENDS:     reg_mask = MSK_ENDS;
         REG_RES_LO:   reg_mask = MSK_RESULT;
         REG_RES_MID:  reg_mask = MSK_RESULT;
         REG_RES_HI:   reg_mask = MSK_RESULT;
         REG_CTRL_A:   reg_mask = MSK_CTRL_A;
         REG_CTRL_B:   reg_mask = MSK_CTRL_B;
         REG_CLKDIV:   reg_mask = MSK_CLKDIV;
         REG_DAC_HI:   reg_mask = MSK_DAC_HI;
         REG_DAC_LO:   reg_mask = MSK_DAC_LO;
         REG_DAC_CTRL: reg_mask = MSK_DAC_CTRL;
         default:      reg_mask = 8'h00;
      endcase
   endfunction : reg_mask

   // end select code to one-hot source; reserved codes route nothing
   function automatic logic [5:0] route_of(input logic [2:0] c);
      route_of = 6'h00;
      case (c)
         3'h0:    route_of[SRC_AIN_A] = 1'b1;
         3'h1:    route_of[SRC_AIN_B] = 1'b1;
         3'h4:    route_of[SRC_DAC]   = 1'b1;
         3'h5:    route_of[SRC_GND]   = 1'b1;
         3'h6:    route_of[SRC_CM]    = 1'b1;
         3'h7:    route_of[SRC_TEMP]  = 1'b1;
         default: route_of = 6'h00;
      endcase
   endfunction : route_of

   // sign-magnitude offset code to signed quarter steps
   function automatic logic signed [2:0] offset_of(input logic [2:0] c);
      offset_of = c[2] ? -$signed({1'b0, c[1:0]})
                       :  $signed({1'b0, c[1:0]});
   endfunction : offset_of

   // read mux; result bytes come straight from the datapath
   always_comb begin
      case (addr)
         REG_SUPPLY:   rd_val = s_r.supply;
         REG_GAIN:     rd_val = s_r.gain;
         REG_LINK:     rd_val = s_r.link;
         REG_ENDS:     rd_val = s_r.ends;
         REG_RES_LO:   rd_val = result_word[7:0];
         REG_RES_MID:  rd_val = result_word[15:8];
         REG_RES_HI:   rd_val = result_word[23:16];
         REG_CTRL_A:   rd_val = s_r.ctrl_a;
         REG_CTRL_B:   rd_val = s_r.ctrl_b;
         REG_CLKDIV:   rd_val = s_r.clkdiv;
         REG_DAC_HI:   rd_val = s_r.dac_hi;
         REG_DAC_LO:   rd_val = s_r.dac_lo;
         REG_DAC_CTRL: rd_val = s_r.dac_ctrl;
         default:      rd_val = 8'h00;
      endcase
   end

   // next bank: writes, eoc set, read answer, decodes
   always_comb begin
      s_nxt = s_r;
      if (ce) begin
         // read data stand for one cycle only
         s_nxt.rdata = 8'h00;
         if (rd_stb) begin
            s_nxt.rdata = rd_val & reg_mask(addr);
         end
         if (wr_stb) begin
            // masking drops writes to unimplemented bits
            case (addr)
               REG_SUPPLY: s_nxt.supply = wdata & MSK_SUPPLY;
               REG_GAIN:   s_nxt.gain   = wdata & MSK_GAIN;
               REG_LINK:   s_nxt.link   = wdata & MSK_LINK;
               REG_ENDS:   s_nxt.ends   = wdata & MSK_ENDS;
               REG_CTRL_A: s_nxt.ctrl_a = wdata & MSK_CTRL_A;
               REG_CTRL_B: s_nxt.ctrl_b = wdata & MSK_CTRL_B;
               REG_CLKDIV: s_nxt.clkdiv = wdata & MSK_CLKDIV;
               REG_DAC_HI: begin
                  // high write commits the pending low nibble
                  s_nxt.dac_hi = wdata & MSK_DAC_HI;
                  s_nxt.dac_lo = s_r.dac_shd;
               end
               REG_DAC_LO: begin
                  // lands in the shadow, active code untouched
                  s_nxt.dac_shd = wdata & MSK_DAC_LO;
               end
               REG_DAC_CTRL: s_nxt.dac_ctrl = wdata & MSK_DAC_CTRL;
               default: begin
                  // result bytes and holes ignore writes
                  s_nxt.rdata = s_nxt.rdata;
               end
            endcase
         end
         // a conversion end beats a software clear
         if (eoc_set) begin
            s_nxt.ctrl_b[B_EOC_BIT] = 1'b1;
         end
         // decodes follow the fields in the same edge
         s_nxt.reg_pwr  = !(s_nxt.ctrl_a[A_OFF_BIT]
                            && !s_nxt.supply[SUP_ON_BIT]);
         s_nxt.amp_gain = 8'h01 << s_nxt.gain[2:0];
         s_nxt.in_gain  = 4'h1 << s_nxt.gain[G_IN_LSB +: 2];
         s_nxt.offset   = offset_of(s_nxt.link[L_OFS_LSB +: 3]);
         s_nxt.pos_rt   = route_of(s_nxt.ends[2:0]);
         s_nxt.neg_rt   = route_of(s_nxt.ends[E_NEG_LSB +: 3]);
      end
   end

   // bank register, synchronous reset to power-on image
   always_ff @(posedge core_clk) begin
      if (!rstn) s_r <= BANK_RST;
      else       s_r <= s_nxt;
   end

   // power-off dominates sleep and soft reset
   assign conv_run = !s_r.ctrl_a[A_OFF_BIT]
                     && !s_r.ctrl_a[A_SLP_BIT]
                     && !s_r.ctrl_a[A_RST_BIT];

   // modulator clock source
   mod_clock_div u_mclk (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .ce        (ce),
      .div_sel   (s_r.clkdiv[4:0]),
      .mclk_tick (modulator_tick)
   );

   // output word slots from n, sample_doubling_factor and osr
   word_rate_div u_rate (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .ce          (ce),
      .run         (conv_run),
      .mclk_tick   (modulator_tick),
      .filter_mode (s_r.ctrl_b[B_FLM_LSB +: 3]),
      .osr_sel     (s_r.ctrl_a[A_OSR_LSB +: 3]),
      .word_tick   (word_rate_tick)
   );

   // register port answer
   assign rdata = s_r.rdata;

   // regulator; level code drives the regulator taps as is
   assign regulator_level_sel = s_r.supply[1:0];
   assign regulator_on        = s_r.supply[SUP_ON_BIT];
   assign regulator_bypass    = s_r.supply[SUP_BPS_BIT];
   assign regulator_power     = s_r.reg_pwr;
   assign regulated_output_en = s_r.supply[SUP_ON_BIT];
   assign common_mode_en      = s_r.reg_pwr;

   // converter control fields
   assign converter_power_off  = s_r.ctrl_a[A_OFF_BIT];
   assign converter_sleep      = s_r.ctrl_a[A_SLP_BIT];
   assign converter_soft_reset = s_r.ctrl_a[A_RST_BIT];
   assign oversampling_sel     = s_r.ctrl_a[A_OSR_LSB +: 3];
   assign ext_reference_sel    = s_r.ctrl_a[A_VREF_BIT];
   assign filter_mode_sel      = s_r.ctrl_b[B_FLM_LSB +: 3];
   // high when sample_doubling_factor is one: doubling disabled
   assign sample_doubling_factor = s_r.ctrl_b[B_FLM_LSB + 2];
   assign ref_buf_neg_en       = s_r.ctrl_b[B_BUFN_BIT];
   assign ref_buf_pos_en       = s_r.ctrl_b[B_BUFP_BIT];
   assign data_latch_en        = s_r.ctrl_b[B_LATCH_BIT];
   assign modulator_clock_div  = s_r.clkdiv[4:0];

   // gains; reserved reference code is passed on unchanged
   assign reference_gain_sel   = s_r.gain[G_REF_LSB +: 2];
   assign converter_input_gain = s_r.in_gain;
   assign amplifier_gain       = s_r.amp_gain;

   // input network
   assign input_short          = s_r.link[L_SHORT_BIT];
   assign input_crossover_sel  = s_r.link[L_XOVER_LSB +: 2];
   assign diff_offset_quarters = s_r.offset;
   // no check that software keeps the pairing advice
   assign positive_route       = s_r.pos_rt;
   assign negative_route       = s_r.neg_rt;

   // dac
   assign dac_code   = {s_r.dac_hi, s_r.dac_lo[3:0]};
   assign dac_enable = s_r.dac_ctrl[DC_EN_BIT];
   assign dac_ref_sel = s_r.dac_ctrl[DC_REF_LSB +: 2];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   property p_level;
      ce && wr_stb && addr == REG_SUPPLY
      |=> regulator_level_sel == $past(wdata[1:0]);
   endproperty
   a_level: assert property (p_level)
      else $error("regulator level not taken from write");

   property p_power;
      regulator_power == !(converter_power_off && !regulator_on);
   endproperty
   a_power: assert property (p_power)
      else $error("regulator power disagrees with controls");

   property p_bypass;
      ce && wr_stb && addr == REG_SUPPLY
      |=> regulator_bypass == $past(wdata[SUP_BPS_BIT]);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass bit not taken from write");

   property p_amp;
      ce && wr_stb && addr == REG_GAIN
      |=> amplifier_gain == (8'h01 << $past(wdata[2:0]));
   endproperty
   a_amp: assert property (p_amp)
      else $error("amplifier gain decode wrong");

   property p_route;
      ce && wr_stb && addr == REG_ENDS
      |=> $onehot0(positive_route) && $onehot0(negative_route)
          && positive_route[SRC_TEMP] == ($past(wdata[2:0]) == 3'h7)
          && negative_route[SRC_CM] == ($past(wdata[5:3]) == 3'h6);
   endproperty
   a_route: assert property (p_route)
      else $error("input end routing decode wrong");

   property p_shadow;
      ce && wr_stb && addr == REG_DAC_LO |=> $stable(dac_code);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("low code write changed active dac code");

   property p_commit;
      ce && wr_stb && addr == REG_DAC_LO ##1
      ce && wr_stb && addr == REG_DAC_HI
      |=> dac_code == {$past(wdata), $past(wdata[3:0], 2)};
   endproperty
   a_commit: assert property (p_commit)
      else $error("high write did not commit shadow");

   property p_zero_bits;
      ce && rd_stb |=> (rdata & ~reg_mask($past(addr))) == 8'h00
                       ##1 (!$past(ce) || !$past(rd_stb, 2)
                            || rdata == 8'h00 || $past(rd_stb));
   endproperty
   a_zero_bits: assert property (p_zero_bits)
      else $error("unimplemented bits read nonzero");

   property p_off_words;
      converter_power_off [*2] |-> !word_rate_tick;
   endproperty
   a_off_words: assert property (p_off_words)
      else $error("word pulse while powered off");

   property p_eoc;
      ce && eoc_set |=> s_r.ctrl_b[B_EOC_BIT];
   endproperty
   a_eoc: assert property (p_eoc)
      else $error("end flag lost against a clear");
endmodule : adc_frontend_config_regs

/* File: testbench/testbench.sv */
// self-checking bench for the front-end configuration bank
`timescale 1ns/1ns
module testbench
   import afe_cfg_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        ce       = 1'b1;
   logic        eoc_set  = 1'b0;
   logic        wr_stb   = 1'b0;
   logic        rd_stb   = 1'b0;
   logic [3:0]  addr     = 4'h0;
   logic [7:0]  wdata    = 8'h00;
   logic [23:0] result_word = 24'h000000;
   logic [7:0]  rdata, amp, v, lo;
   logic [1:0]  lvl, rgs, xov;
   logic [3:0]  ing;
   logic [5:0]  pr, nr;
   logic [11:0] dac, ed;
   logic signed [2:0] ofs;
   logic        pwr, oen, cmen, byp, shrt, dbl, mtk, wtk, poff;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          seed = 49;

   // 50 ns period
   always #25 core_clk = ~core_clk;

   // enable and end-of-conversion pulse come from the scenarios
   adc_frontend_config_regs DUT (
      .core_clk(core_clk), .rstn(rstn), .ce(ce), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .result_word(result_word), .eoc_set(eoc_set),
      .regulator_level_sel(lvl), .regulator_on(), .regulator_bypass(byp),
      .regulator_power(pwr), .regulated_output_en(oen),
      .common_mode_en(cmen), .converter_power_off(poff),
      .converter_sleep(), .converter_soft_reset(), .oversampling_sel(),
      .ext_reference_sel(), .filter_mode_sel(),
      .sample_doubling_factor(dbl), .ref_buf_neg_en(),
      .ref_buf_pos_en(), .data_latch_en(), .modulator_clock_div(),
      .reference_gain_sel(rgs), .converter_input_gain(ing),
      .amplifier_gain(amp), .input_short(shrt), .input_crossover_sel(xov),
      .diff_offset_quarters(ofs), .positive_route(pr),
      .negative_route(nr), .dac_code(dac), .dac_enable(), .dac_ref_sel(),
      .modulator_tick(mtk), .word_rate_tick(wtk));

   // one compare for every kind of value
   task automatic chk(string n, logic [11:0] e, logic [11:0] s);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // one-cycle write, idle cycle after so strobes never retoggle
   task automatic wr(logic [3:0] a, logic [7:0] d);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   // read; answer stands only in the cycle after the strobe
   task automatic rdc(logic [3:0] a, logic [7:0] e);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 chk("rdata", e, rdata);
      @(posedge core_clk);
   endtask : rdc

   // edges from one tick to the next; a lost tick runs out the bound
   task automatic gap(string n, int e, bit w);
      int c;
      repeat (2) begin
         c = 0;
         do begin
            @(posedge core_clk);
            c++;
         end while (!(w ? wtk : mtk) && c < 2000);
      end
      chk(n, e[11:0], c[11:0]);
   endtask : gap

   // one-hot source for an input-end code, reserved codes route nothing
   function automatic logic [5:0] route(logic [2:0] c);
      if (c[2:1] == 2'b01)
         return 6'h00;
      return 6'h01 << (c[2] ? c[1:0] + 3'd2 : {1'b0, c[1:0]});
   endfunction : route

   // sign-magnitude quarter steps
   function automatic logic signed [2:0] quarters(logic [2:0] c);
      return c[2] ? -$signed({1'b0, c[1:0]}) : $signed({1'b0, c[1:0]});
   endfunction : quarters

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rdc(REG_SUPPLY, 8'h00);
      rdc(REG_CTRL_A, RST_CTRL_A);
      chk("route", 6'h01, pr);
      chk("off", 12'h001, {11'h0, poff});
      ed = 12'h000;
      // every power-off and enable pairing
      for (int i = 0; i < 4; i++) begin
         wr(REG_CTRL_A, {2'b00, i[1], 5'h00});
         wr(REG_SUPPLY, {i[0], 7'h00});
         chk("power", {11'h0, !(i[1] & !i[0])}, {11'h0, pwr});
         chk("vout", {11'h0, i[0]}, {11'h0, oen});
         chk("cm", {11'h0, !(i[1] & !i[0])}, {11'h0, cmen});
      end
      // random fields, reserved codes and masked bits among them
      for (int i = 0; i < 40; i++) begin
         v = $random(seed);
         // software keeps the temperature outputs paired
         if (v[2:0] == 3'h7 || v[5:3] == 3'h7)
            v[5:0] = 6'h3f;
         wr(REG_GAIN, v);
         rdc(REG_GAIN, v & MSK_GAIN);
         chk("amp", 12'h1 << v[2:0], {4'h0, amp});
         chk("ing", 12'h1 << v[4:3], {8'h0, ing});
         chk("rgs", v[6:5], rgs);
         wr(REG_LINK, v);
         chk("ofs", quarters(v[3:1]), ofs);
         chk("short", v[6], shrt);
         chk("xov", v[5:4], xov);
         wr(REG_ENDS, v);
         chk("pos", route(v[2:0]), pr);
         chk("neg", route(v[5:3]), nr);
         wr(REG_SUPPLY, v);
         rdc(REG_SUPPLY, v & MSK_SUPPLY);
         chk("lvl", v[1:0], lvl);
         chk("byp", v[2], byp);
         lo = $random(seed);
         wr(REG_DAC_LO, lo);
         chk("dac", ed, dac);
         rdc(REG_DAC_LO, ed[3:0]);
         wr(REG_DAC_HI, v);
         ed = {v, lo[3:0]};
         chk("dac", ed, dac);
         result_word <= $random(seed);
         wr(REG_RES_MID, v);
         rdc(REG_RES_MID, result_word[15:8]);
         rdc(4'hd, 8'h00);
      end
      // single-ended input, common mode on the far end
      wr(REG_ENDS, 8'h30);
      chk("neg", route(3'h6), nr);
      // low then high with no gap commits the new low code
      lo = $random(seed);
      addr   <= REG_DAC_LO;
      wdata  <= lo;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      addr   <= REG_DAC_HI;
      wdata  <= v;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      @(posedge core_clk);
      chk("dac", {v, lo[3:0]}, dac);
      // a write under a frozen enable is dropped
      ce <= 1'b0;
      wr(REG_GAIN, ~v);
      ce <= 1'b1;
      rdc(REG_GAIN, v & MSK_GAIN);
      // end of conversion beats a clear in the same cycle
      addr    <= REG_CTRL_B;
      wdata   <= 8'h00;
      wr_stb  <= 1'b1;
      eoc_set <= 1'b1;
      @(posedge core_clk);
      wr_stb  <= 1'b0;
      eoc_set <= 1'b0;
      @(posedge core_clk);
      rdc(REG_CTRL_B, 8'h02);
      wr(REG_CTRL_B, 8'hc0);
      rdc(REG_CTRL_B, 8'hc0);
      chk("sample_doubling_factor", 12'h001, {11'h0, dbl});
      // run the converter: osr 128, n 12, sample_doubling_factor 1
      wr(REG_CTRL_A, 8'h1c);
      wr(REG_CLKDIV, {5'h00, v[2:0]});
      gap("mclk", 2 * (v[2:0] + 1), 1'b0);
      wr(REG_CLKDIV, 8'h1f);
      gap("mclk", 1, 1'b0);
      gap("word", DIV_N_FAST * SAMPLE_DOUBLING_FACTOR_SINGLE * (OSR_MAX >> 7),
          1'b1);
      // reset again in mid-run
      rstn <= 1'b0;
      @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      chk("dac", 12'h000, dac);
      rdc(REG_CTRL_A, RST_CTRL_A);
      end_sim();
   end
endmodule : testbench
